// [verilog/rcr_pkg.sv]
// Register map, field positions, reset values and widths of the reset cause block.
// Assumes a 32-bit APB with word-aligned registers inside a 4 KB window.
package rcr_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CAUSE     = 12'h000;
  localparam logic [11:0] OFF_PERIPH    = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h00c;

  // ---------------------------------------------------------------
  // Reset cause register fields
  // ---------------------------------------------------------------
  localparam int NUM_FLAGS     = 6;
  localparam int FLAG_LSB      = 26;
  localparam int BIT_LOW_PWR   = 31;
  localparam int BIT_WWDG      = 30;
  localparam int BIT_IWDG      = 29;
  localparam int BIT_SOFT      = 28;
  localparam int BIT_POWER     = 27;
  localparam int BIT_PIN       = 26;
  localparam int BIT_OPAMP     = 25;
  localparam int BIT_CLEAR_ALL = 24;

  // Flag vector index order: pin, power, soft, iwdg, wwdg, low power
  localparam logic [5:0] FLAG_POR_VALUE = 6'h02;

  // ---------------------------------------------------------------
  // Peripheral reset register fields
  // ---------------------------------------------------------------
  localparam int BIT_PD_RST  = 17;
  localparam int BIT_PIO_RST = 13;
  localparam int BIT_USB_RST = 12;
  localparam logic [2:0] PERIPH_RST_VALUE = 3'h0;

endpackage

// [verilog/rcr_flag_if.sv]
// Carrier between the top and the power-on-reset flag store.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface rcr_flag_if;
  logic       clear_all;
  logic [5:0] set_pulse;
  logic [5:0] flags;

  modport store (input clear_all, output set_pulse, output flags);
  modport ctrl  (output clear_all, input set_pulse, input flags);
endinterface

// [verilog/rcr_flag_store.sv]
// Sticky reset cause flags, kept across system resets, cleared by a clear-all write and reloaded by power-on reset.
// Assumes reset source indications may arrive from any domain; they are synchronised here.
`timescale 1ns/1ps
module rcr_flag_store (
  // Clock and power-on reset
  input  wire logic pclk,
  input  wire logic por_n,
  // Reset source indications
  input  wire logic low_power_reset_req,
  input  wire logic window_watchdog_reset_req,
  input  wire logic independent_watchdog_reset_req,
  input  wire logic software_reset_req,
  input  wire logic power_down_reset_req,
  input  wire logic external_reset_pin_n,
  // Link to the register side
  rcr_flag_if.store fl
);

  // ---------------------------------------------------------------
  // Synchronisers and assertion edge detect
  // ---------------------------------------------------------------
  logic [5:0] raw;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] sync3_q;
  logic [5:0] flags_q;
  logic [5:0] flags_d;

  assign raw = {low_power_reset_req, window_watchdog_reset_req, independent_watchdog_reset_req,
                software_reset_req, power_down_reset_req, ~external_reset_pin_n};

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sync3_q <= 6'h00;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign fl.set_pulse = sync2_q & ~sync3_q;

  // ---------------------------------------------------------------
  // Flags: a new event wins over a clear in the same cycle
  // ---------------------------------------------------------------
  assign flags_d = (flags_q & ~{6{fl.clear_all}}) | fl.set_pulse;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      flags_q <= rcr_pkg::FLAG_POR_VALUE;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_flag_set_sticks: assert property (@(posedge pclk) disable iff (!por_n)
    (fl.set_pulse != 6'h00) |=> ((flags_q & $past(fl.set_pulse)) == $past(fl.set_pulse)))
    else $error("reset cause flag not set by its event");

  a_flag_clear_all: assert property (@(posedge pclk) disable iff (!por_n)
    (fl.clear_all && fl.set_pulse == 6'h00) |=> (flags_q == 6'h00))
    else $error("flags not cleared by clear-all");

  a_flag_hold: assert property (@(posedge pclk) disable iff (!por_n)
    (!fl.clear_all && fl.set_pulse == 6'h00) |=> $stable(flags_q))
    else $error("flags changed without event or clear");

  c_clear_collides: cover property (@(posedge pclk) disable iff (!por_n)
    fl.clear_all && fl.set_pulse != 6'h00);

endmodule // rcr_flag_store

// [verilog/rcr_top.sv]
// APB register block for reset cause flags, peripheral resets and an event interrupt.
// Assumes presetn is the system reset and por_n the power-on reset, both async active low.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module rcr_top (
  // APB clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset source indications
  input  wire logic        low_power_reset_req,
  input  wire logic        window_watchdog_reset_req,
  input  wire logic        independent_watchdog_reset_req,
  input  wire logic        software_reset_req,
  input  wire logic        power_down_reset_req,
  input  wire logic        external_reset_pin_n,
  // Peripheral reset requests and op-amp flag pulse
  output logic             power_delivery_module_reset,
  output logic             protocol_io_module_reset,
  output logic             fullspeed_usb_module_reset,
  output logic             op_amp_reset_flag_control,
  // Interrupt
  output logic             irq
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SEL_CAUSE  = 5'b00001,
    SEL_PERIPH = 5'b00010,
    SEL_STAT   = 5'b00100,
    SEL_MASK   = 5'b01000,
    SEL_NONE   = 5'b10000
  } rcr_sel_t;

  function automatic rcr_sel_t rcr_decode(input logic [11:0] addr);
    case (addr)
      rcr_pkg::OFF_CAUSE:    rcr_decode = SEL_CAUSE;
      rcr_pkg::OFF_PERIPH:   rcr_decode = SEL_PERIPH;
      rcr_pkg::OFF_IRQ_STAT: rcr_decode = SEL_STAT;
      rcr_pkg::OFF_IRQ_MASK: rcr_decode = SEL_MASK;
      default:               rcr_decode = SEL_NONE;
    endcase
  endfunction

  rcr_flag_if fl ();

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        access;
  logic        wr_en;
  rcr_sel_t    sel;
  logic [2:0]  periph_q;
  logic        opamp_q;
  logic [5:0]  stat_q;
  logic [5:0]  stat_d;
  logic [5:0]  mask_q;
  logic        irq_q;
  logic [31:0] rd_word;

  // A held request is taken once: the answer cycle blocks a second take
  assign sel    = rcr_decode(paddr);
  assign access = psel && penable && !pready_q;
  assign wr_en  = psel && penable && pready_q && pwrite;

  // ---------------------------------------------------------------
  // Flag store, kept alive across system reset
  // ---------------------------------------------------------------
  assign fl.clear_all = wr_en && sel == SEL_CAUSE && pwdata[rcr_pkg::BIT_CLEAR_ALL];

  rcr_flag_store u_store (
    .pclk                           (pclk),
    .por_n                          (por_n),
    .low_power_reset_req            (low_power_reset_req),
    .window_watchdog_reset_req      (window_watchdog_reset_req),
    .independent_watchdog_reset_req (independent_watchdog_reset_req),
    .software_reset_req             (software_reset_req),
    .power_down_reset_req           (power_down_reset_req),
    .external_reset_pin_n           (external_reset_pin_n),
    .fl                             (fl)
  );

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    case (sel)
      SEL_CAUSE: begin
        rd_word[31:rcr_pkg::FLAG_LSB] = fl.flags;
      end
      SEL_PERIPH: begin
        rd_word[rcr_pkg::BIT_PD_RST]  = periph_q[2];
        rd_word[rcr_pkg::BIT_PIO_RST] = periph_q[1];
        rd_word[rcr_pkg::BIT_USB_RST] = periph_q[0];
      end
      SEL_STAT: begin
        rd_word[5:0] = stat_q;
      end
      SEL_MASK: begin
        rd_word[5:0] = mask_q;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // APB handshake: one wait state on every transfer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && sel == SEL_NONE;
      if (access && !pwrite) begin
        prdata_q <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Peripheral resets and op-amp flag pulse
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_q <= rcr_pkg::PERIPH_RST_VALUE;
    end else if (wr_en && sel == SEL_PERIPH) begin
      periph_q <= {pwdata[rcr_pkg::BIT_PD_RST], pwdata[rcr_pkg::BIT_PIO_RST],
                   pwdata[rcr_pkg::BIT_USB_RST]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opamp_q <= 1'b0;
    end else begin
      opamp_q <= wr_en && sel == SEL_CAUSE && pwdata[rcr_pkg::BIT_OPAMP];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt: sticky event bits, write one to clear, new event wins
  // ---------------------------------------------------------------
  // Status keeps events while masked, so a later unmask still raises irq
  assign stat_d = (wr_en && sel == SEL_STAT) ? (stat_q & ~pwdata[5:0]) | fl.set_pulse
                                              : stat_q | fl.set_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 6'h00;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 6'h00;
    end else if (wr_en && sel == SEL_MASK) begin
      mask_q <= pwdata[5:0];
    end
  end

  // Registered level, one cycle behind the masked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign prdata                      = prdata_q;
  assign pready                      = pready_q;
  assign pslverr                     = pslverr_q;
  assign power_delivery_module_reset = periph_q[2];
  assign protocol_io_module_reset    = periph_q[1];
  assign fullspeed_usb_module_reset  = periph_q[0];
  assign op_amp_reset_flag_control   = opamp_q;
  assign irq                         = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    access |=> pready_q ##1 !pready_q)
    else $error("APB answer not after exactly one wait state");

  a_periph_rst_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_PERIPH)
      |=> (power_delivery_module_reset == $past(pwdata[rcr_pkg::BIT_PD_RST])
      && protocol_io_module_reset == $past(pwdata[rcr_pkg::BIT_PIO_RST])
      && fullspeed_usb_module_reset == $past(pwdata[rcr_pkg::BIT_USB_RST])))
    else $error("peripheral reset outputs do not follow written bits");

  a_periph_rst_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && sel == SEL_PERIPH) |=> $stable(periph_q))
    else $error("peripheral reset changed without a write");

  a_opamp_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_CAUSE && pwdata[rcr_pkg::BIT_OPAMP])
      |=> op_amp_reset_flag_control ##1 !op_amp_reset_flag_control)
    else $error("op-amp flag pulse not a single cycle after a write");

  a_cause_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && sel == SEL_CAUSE) |=> (prdata_q[31:26] == $past(fl.flags)
      && prdata_q[25:0] == 26'h0))
    else $error("cause register read does not show the flags");

  a_flags_survive_sys: assert property (@(posedge pclk) disable iff (!por_n)
    (!presetn && fl.set_pulse == 6'h00) |=> fl.flags == $past(fl.flags))
    else $error("cause flags changed during system reset");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (fl.set_pulse != 6'h00 && (fl.set_pulse & mask_q) != 6'h00 && !(wr_en && sel == SEL_MASK))
      |-> ##2 irq)
    else $error("unmasked event did not raise the interrupt");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (access && sel == SEL_NONE) |=> pslverr && pready)
    else $error("unmapped access not answered with an error");

  a_unmapped_rd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && sel == SEL_NONE) |=> (prdata_q == 32'h0000_0000))
    else $error("unmapped read does not return zero");

  a_periph_rd_back: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && sel == SEL_PERIPH) |=> (prdata_q[rcr_pkg::BIT_PD_RST] == $past(periph_q[2])
      && prdata_q[rcr_pkg::BIT_PIO_RST] == $past(periph_q[1])
      && prdata_q[rcr_pkg::BIT_USB_RST] == $past(periph_q[0])))
    else $error("peripheral register read does not show the reset bits");

  a_ready_from_access: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q |-> $past(access))
    else $error("APB answer without a taken request");

  a_err_only_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_q |-> $past(access && sel == SEL_NONE))
    else $error("APB error on a mapped register");

  a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && !pwrite) |=> $stable(prdata_q))
    else $error("read data changed without a read");

  a_opamp_only_write: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && sel == SEL_CAUSE && pwdata[rcr_pkg::BIT_OPAMP]) |=> !op_amp_reset_flag_control)
    else $error("op-amp flag pulse without a write of one");

  // ---------------------------------------------------------------
  // Assertions: interrupt status and mask; covers: clear-all, peripheral resets, irq, status collision
  // ---------------------------------------------------------------
  a_stat_event_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (fl.set_pulse != 6'h00) |=> ((stat_q & $past(fl.set_pulse)) == $past(fl.set_pulse)))
    else $error("interrupt status bit not set by its event");

  a_stat_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_STAT && fl.set_pulse == 6'h00)
      |=> ((stat_q & $past(pwdata[5:0])) == 6'h00))
    else $error("interrupt status bit not cleared by writing one");

  a_stat_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!(wr_en && sel == SEL_STAT) && fl.set_pulse == 6'h00) |=> $stable(stat_q))
    else $error("interrupt status changed without event or clear");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_MASK) |=> (mask_q == $past(pwdata[5:0])))
    else $error("interrupt mask does not take the written value");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (irq == $past(|(stat_q & mask_q))))
    else $error("interrupt level does not follow masked status");

  c_clear_all_write: cover property (@(posedge pclk) disable iff (!presetn) fl.clear_all);
  c_periph_held: cover property (@(posedge pclk) disable iff (!presetn)
    power_delivery_module_reset && protocol_io_module_reset && fullspeed_usb_module_reset);
  c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_stat_collides: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel == SEL_STAT && fl.set_pulse != 6'h00);

endmodule // rcr_top

// [test/rcr_top_tb_top.sv]
// Self-checking bench for the reset cause and peripheral reset block, driven over APB.
// Assumes rcr_top on a 50 MHz pclk with async active-low presetn and por_n.
`timescale 1ns/1ps
module rcr_top_tb_top;
  // ---------------------------------------------------------------
  // Signals and instance
  // ---------------------------------------------------------------
  logic        pclk, presetn, por_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exp_q, rd_q;
  logic        pready, pslverr, pd_rst, pio_rst, usb_rst, amp, irq, err_q;
  logic [5:0]  src;
  int          fails, checks, amp_cnt;

  rcr_top dut (
    .pclk                           (pclk),
    .presetn                        (presetn),
    .por_n                          (por_n),
    .psel                           (psel),
    .penable                        (penable),
    .pwrite                         (pwrite),
    .paddr                          (paddr),
    .pwdata                         (pwdata),
    .prdata                         (prdata),
    .pready                         (pready),
    .pslverr                        (pslverr),
    .low_power_reset_req            (src[5]),
    .window_watchdog_reset_req      (src[4]),
    .independent_watchdog_reset_req (src[3]),
    .software_reset_req             (src[2]),
    .power_down_reset_req           (src[1]),
    .external_reset_pin_n           (~src[0]),
    .power_delivery_module_reset    (pd_rst),
    .protocol_io_module_reset       (pio_rst),
    .fullspeed_usb_module_reset     (usb_rst),
    .op_amp_reset_flag_control      (amp),
    .irq                            (irq)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held from setup until pready is seen high; released on the edge that samples it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    logic        s;
    apb(1'b0, a, 32'h0, r, s);
    chk(nm, e, r);
  endtask

  // Holds one reset source active for three cycles, then lets the sync chain settle
  task automatic ev(input int i);
    @(posedge pclk);
    src[i] <= 1'b1;
    repeat (3) @(posedge pclk);
    src[i] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic settle_chk(input string nm, input logic [31:0] e);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(nm, e, {26'h0, pd_rst, pio_rst, usb_rst, amp, irq, 1'b0});
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (amp === 1'b1)
      amp_cnt++;
  end

  // Tests take about 300 cycles; allow some thirty times that
  initial begin
    #200us;
    fails++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    por_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    src     = 6'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    settle_chk("outputs_reset", 32'h0);
    rdc(rcr_pkg::OFF_CAUSE, 32'h08000000, "cause_power_on");
    rdc(rcr_pkg::OFF_PERIPH, 32'h0, "periph_reset");
    wr(rcr_pkg::OFF_CAUSE, 32'hfc000000);
    rdc(rcr_pkg::OFF_CAUSE, 32'h08000000, "cause_no_clear");
    wr(rcr_pkg::OFF_CAUSE, 32'h01000000);
    rdc(rcr_pkg::OFF_CAUSE, 32'h0, "cause_cleared");
    exp_q = 32'h0;
    for (int i = 0; i < rcr_pkg::NUM_FLAGS; i++) begin
      ev(i);
      exp_q = exp_q | (32'h1 << (rcr_pkg::FLAG_LSB + i));
      rdc(rcr_pkg::OFF_CAUSE, exp_q, "cause_event");
    end
    rdc(rcr_pkg::OFF_IRQ_STAT, 32'h3f, "irq_status_all");
    // System reset keeps the flags but clears everything else
    wr(rcr_pkg::OFF_PERIPH, 32'h00023000);
    wr(rcr_pkg::OFF_IRQ_MASK, 32'h3f);
    settle_chk("outputs_set", 32'h3a);
    @(posedge pclk);
    presetn <= 1'b0;
    settle_chk("outputs_in_reset", 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rdc(rcr_pkg::OFF_CAUSE, 32'hfc000000, "cause_kept");
    rdc(rcr_pkg::OFF_PERIPH, 32'h0, "periph_cleared");
    rdc(rcr_pkg::OFF_IRQ_MASK, 32'h0, "mask_cleared");
    rdc(rcr_pkg::OFF_IRQ_STAT, 32'h0, "stat_cleared");
    // Op-amp control gives one pulse per write of one, none for zero
    wr(rcr_pkg::OFF_CAUSE, 32'h02000000);
    settle_chk("no_pulse_left", 32'h0);
    chk("amp_pulses", 32'h1, amp_cnt);
    rdc(rcr_pkg::OFF_CAUSE, 32'hfc000000, "cause_after_amp");
    wr(rcr_pkg::OFF_CAUSE, 32'h0);
    settle_chk("amp_zero", 32'h0);
    chk("amp_pulses_zero", 32'h1, amp_cnt);
    wr(rcr_pkg::OFF_CAUSE, 32'h01000000);
    // Interrupt raise, clear, mask
    wr(rcr_pkg::OFF_IRQ_MASK, 32'h1);
    ev(0);
    settle_chk("irq_raised", 32'h2);
    wr(rcr_pkg::OFF_IRQ_STAT, 32'h1);
    settle_chk("irq_cleared", 32'h0);
    ev(2);
    rdc(rcr_pkg::OFF_IRQ_STAT, 32'h4, "irq_status_soft");
    settle_chk("irq_masked", 32'h0);
    wr(rcr_pkg::OFF_IRQ_MASK, 32'h5);
    settle_chk("irq_unmasked", 32'h2);
    wr(rcr_pkg::OFF_IRQ_STAT, 32'h4);
    settle_chk("irq_cleared_2", 32'h0);
    rdc(rcr_pkg::OFF_CAUSE, 32'h14000000, "cause_pin_soft");
    // A clear landing in the cycle of a new event keeps the new flag
    fork
      ev(5);
      wr(rcr_pkg::OFF_CAUSE, 32'h01000000);
    join
    rdc(rcr_pkg::OFF_CAUSE, 32'h80000000, "cause_clear_collide");
    // Each peripheral reset held while its bit is one, released on zero
    for (int k = 0; k < 3; k++) begin
      exp_q = (k == 0) ? 32'h00020000 : ((k == 1) ? 32'h00002000 : 32'h00001000);
      wr(rcr_pkg::OFF_PERIPH, exp_q);
      settle_chk("periph_one", 32'h20 >> k);
      rdc(rcr_pkg::OFF_PERIPH, exp_q, "periph_readback");
    end
    wr(rcr_pkg::OFF_PERIPH, 32'hffffffff);
    rdc(rcr_pkg::OFF_PERIPH, 32'h00023000, "periph_all");
    apb(1'b1, 12'h010, 32'h0, rd_q, err_q);
    chk("unmapped_wr_err", 32'h1, {31'h0, err_q});
    settle_chk("periph_unmapped_wr", 32'h38);
    apb(1'b0, 12'h010, 32'h0, rd_q, err_q);
    chk("unmapped_err", 32'h1, {31'h0, err_q});
    chk("unmapped_data", 32'h0, rd_q);
    wr(rcr_pkg::OFF_PERIPH, 32'h0);
    settle_chk("periph_released", 32'h0);
    // Power-on reset in mid-run restores the flags
    ev(3);
    @(posedge pclk);
    por_n <= 1'b0;
    repeat (2) @(posedge pclk);
    por_n <= 1'b1;
    rdc(rcr_pkg::OFF_CAUSE, 32'h08000000, "cause_second_por");
    finish_test();
  end
endmodule // rcr_top_tb_top
